// ---- hdl/wakeup_frame_filter.v ----
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "wake_filter_regs.vh"
module wakeup_frame_filter
#(
    parameter NFILT = 8
)
(
    input  wire        clk,
    input  wire        resetn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        rxFrameStart,
    input  wire        rxByteValid,
    input  wire [7:0]  rxByteData,
    input  wire        rxFrameEnd,
    input  wire        rxIsUnicast,
    input  wire        rxIsMulticast,
    input  wire        rxIsBroadcast,
    input  wire        rxPassedFilter,
    output reg         wakeEvent,
    output reg         wakeFrameSeen
);
    reg  [31:0]        maskWord [0:4*NFILT-1];
    reg  [3:0]         filterCmd [0:NFILT-1];
    reg  [7:0]         patOffset [0:NFILT-1];
    reg  [15:0]        patCrc [0:NFILT-1];
    reg  [31:0]        ctrl;
    reg  [NFILT-1:0]   hitLog;
    reg  [10:0]        bytePos;
    wire [16*NFILT-1:0] crcBus;
    reg  [NFILT-1:0]   hit;
    reg  [31:0]        rdData;
    reg  [31:0]        wrMerged;
    integer            i;

    wire       access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [7:0] winRel = wb_adr_i - `WK_WINDOW_BASE;
    wire [5:0] widx = winRel[7:2];
    wire       inWindow = (wb_adr_i >= `WK_WINDOW_BASE) && (widx < `WK_WINDOW_WORDS);
    wire [5:0] cmdIdx = widx - `WK_CMD_WORD;
    wire [5:0] ofsIdx = widx - `WK_OFS_WORD;
    wire [5:0] crcIdx = widx - `WK_CRC_WORD;

    genvar g;
    generate
        for (g = 0; g < NFILT; g = g + 1)
        begin : gLane
            wake_crc_lane uLane
            (
                .clk           (clk),
                .resetn        (resetn),
                .frameStart    (rxFrameStart),
                .byteValid     (rxByteValid),
                .byteData      (rxByteData),
                .bytePos       (bytePos),
                .patternOffset (patOffset[g]),
                .byteMask      ({maskWord[4*g+3], maskWord[4*g+2],
                                 maskWord[4*g+1], maskWord[4*g]}),
                .crc           (crcBus[16*g +: 16])
            );
        end
    endgenerate

    // Byte position counter, zero at first destination address byte
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            bytePos <= 11'h000;
        else if (rxFrameStart)
            bytePos <= 11'h000;
        else if (rxByteValid && bytePos != 11'h7FF)
            bytePos <= bytePos + 11'h001;
    end

    // Per-filter wake decision, taken combinationally at frame end
    always @*
    begin
        for (i = 0; i < NFILT; i = i + 1)
        begin
            hit[i] = 1'b0;
            if (filterCmd[i][`WK_CMD_ENABLE] &&
                crcBus[16*i +: 16] == patCrc[i])
            begin
                if (rxIsUnicast && ctrl[`WK_CTRL_UCAST_EN])
                    hit[i] = 1'b1;
                if (rxIsBroadcast)
                    hit[i] = 1'b1;
                if (rxPassedFilter)
                begin
                    if (filterCmd[i][`WK_CMD_ATYPE_LO])
                        hit[i] = 1'b1;
                    else if (!filterCmd[i][`WK_CMD_ATYPE_HI] && rxIsUnicast)
                        hit[i] = 1'b1;
                    else if (filterCmd[i][`WK_CMD_ATYPE_HI] && rxIsMulticast)
                        hit[i] = 1'b1;
                end
            end
        end
    end

    // Wake output: pulse plus sticky flag, set wins over clear
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wakeEvent     <= 1'b0;
            wakeFrameSeen <= 1'b0;
            hitLog        <= {NFILT{1'b0}};
        end
        else
        begin
            wakeEvent <= rxFrameEnd && ctrl[`WK_CTRL_FRAME_EN] && (|hit);
            if (rxFrameEnd && ctrl[`WK_CTRL_FRAME_EN] && (|hit))
            begin
                wakeFrameSeen <= 1'b1;
                hitLog        <= hitLog | hit;
            end
            else if (access && wb_we_i && wb_adr_i == `WK_STATUS_ADDR && wb_sel_i[0] &&
                     wb_dat_i[`WK_STAT_WAKE])
            begin
                wakeFrameSeen <= 1'b0;
                hitLog        <= {NFILT{1'b0}};
            end
        end
    end

    // Read mux
    always @*
    begin
        rdData = 32'h00000000;
        if (wb_adr_i == `WK_CTRL_ADDR)
            rdData = ctrl;
        else if (wb_adr_i == `WK_STATUS_ADDR)
        begin
            rdData[`WK_STAT_WAKE] = wakeFrameSeen;
            rdData[`WK_STAT_HITS_LO +: NFILT] = hitLog;
        end
        else if (inWindow)
        begin
            if (widx < `WK_CMD_WORD)
                rdData = maskWord[widx[4:0]];
            else if (widx < `WK_OFS_WORD)
                rdData = {4'h0, filterCmd[4*cmdIdx[0]+3], 4'h0, filterCmd[4*cmdIdx[0]+2],
                          4'h0, filterCmd[4*cmdIdx[0]+1], 4'h0, filterCmd[4*cmdIdx[0]]};
            else if (widx < `WK_CRC_WORD)
                rdData = {patOffset[4*ofsIdx[0]+3], patOffset[4*ofsIdx[0]+2],
                          patOffset[4*ofsIdx[0]+1], patOffset[4*ofsIdx[0]]};
            else
                rdData = {patCrc[2*crcIdx[1:0]+1], patCrc[2*crcIdx[1:0]]};
        end
    end

    // Byte-lane merge of write data into current contents
    always @*
    begin
        wrMerged = rdData;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (wb_sel_i[i])
                wrMerged[8*i +: 8] = wb_dat_i[8*i +: 8];
        end
    end

    // Wishbone slave: single-cycle ack, unmapped reads zero, writes dropped
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl     <= `WK_CTRL_RESET;
            for (i = 0; i < 4*NFILT; i = i + 1)
                maskWord[i] <= 32'h00000000;
            for (i = 0; i < NFILT; i = i + 1)
            begin
                filterCmd[i] <= 4'h0;
                patOffset[i] <= 8'h00;
                patCrc[i]    <= 16'h0000;
            end
        end
        else
        begin
            wb_ack_o <= access;
            wb_dat_o <= access ? rdData : 32'h00000000;
            if (access && wb_we_i)
            begin
                if (wb_adr_i == `WK_CTRL_ADDR)
                    ctrl <= wrMerged;
                else if (inWindow)
                begin
                    if (widx < `WK_CMD_WORD)
                        maskWord[widx[4:0]] <= wrMerged;
                    else if (widx < `WK_OFS_WORD)
                    begin
                        for (i = 0; i < 4; i = i + 1)
                            filterCmd[4*cmdIdx[0]+i] <= wrMerged[8*i +: 4];
                    end
                    else if (widx < `WK_CRC_WORD)
                    begin
                        for (i = 0; i < 4; i = i + 1)
                            patOffset[4*ofsIdx[0]+i] <= wrMerged[8*i +: 8];
                    end
                    else
                    begin
                        patCrc[2*crcIdx[1:0]]   <= wrMerged[15:0];
                        patCrc[2*crcIdx[1:0]+1] <= wrMerged[31:16];
                    end
                end
            end
        end
    end
endmodule // wakeup_frame_filter
`default_nettype wire

// ---- include/wake_filter_regs.vh ----
`ifndef WAKE_FILTER_REGS_VH
`define WAKE_FILTER_REGS_VH
// Wishbone byte addresses of the control block
`define WK_CTRL_ADDR        8'h00
`define WK_STATUS_ADDR      8'h04
// Filter window: forty words from this base, word index = mask(32), cmd(2), offset(2), crc(4)
`define WK_WINDOW_BASE      8'h40
`define WK_WINDOW_WORDS     6'd40
`define WK_CMD_WORD         6'd32
`define WK_OFS_WORD         6'd34
`define WK_CRC_WORD         6'd36
// Control register fields
`define WK_CTRL_FRAME_EN    0
`define WK_CTRL_UCAST_EN    9
`define WK_CTRL_BROADCAST_DISABLE_DIS   10
// Command fields
`define WK_CMD_ENABLE       0
`define WK_CMD_ATYPE_LO     2
`define WK_CMD_ATYPE_HI     3
// Status fields
`define WK_STAT_WAKE        0
`define WK_STAT_HITS_LO     8
// Reset values
`define WK_CTRL_RESET       32'h00000000
`define WK_CRC_INIT         16'hFFFF
`endif

// ---- hdl/wake_crc_lane.v ----
`timescale 1ns/10ps
`default_nettype none
`include "wake_filter_regs.vh"
// One filter's running CRC-16 over its selected bytes
module wake_crc_lane
(
    input  wire         clk,
    input  wire         resetn,
    input  wire         frameStart,
    input  wire         byteValid,
    input  wire [7:0]   byteData,
    input  wire [10:0]  bytePos,
    input  wire [7:0]   patternOffset,
    input  wire [127:0] byteMask,
    output reg  [15:0]  crc
);
    wire [11:0] rel = {1'b0, bytePos} - {4'h0, patternOffset};
    wire        inWin = (bytePos >= {3'h0, patternOffset}) && (rel < 12'd128);
    wire        take = byteValid && inWin && byteMask[rel[6:0]];
    wire [7:0]  f;
    wire [15:0] next_crc;

    assign f[0] = crc[15] ^ byteData[0];
    genvar k;
    generate
        for (k = 1; k < 8; k = k + 1)
        begin : gF
            assign f[k] = crc[15-k] ^ f[k-1] ^ byteData[k];
        end
    endgenerate

    assign next_crc = {crc[7] ^ f[7], crc[6:2], crc[1] ^ f[0], crc[0] ^ f[1],
                       f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4], f[3] ^ f[5],
                       f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            crc <= `WK_CRC_INIT;
        else if (frameStart)
            crc <= `WK_CRC_INIT;
        else if (take)
            crc <= next_crc;
    end
endmodule // wake_crc_lane
`default_nettype wire

// ---- test/wakeup_frame_filter_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module wakeup_frame_filter_chk
#(
    parameter NFILT = 8
)
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        rxFrameStart,
    input wire logic        rxByteValid,
    input wire logic [7:0]  rxByteData,
    input wire logic        rxFrameEnd,
    input wire logic        rxIsUnicast,
    input wire logic        rxIsMulticast,
    input wire logic        rxIsBroadcast,
    input wire logic        rxPassedFilter,
    input wire logic        wakeEvent,
    input wire logic        wakeFrameSeen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence wbReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence frameDone;
        rxFrameEnd ##1 wakeEvent;
    endsequence
    AST_ACK_NEXT: assert property (wbReq |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
    AST_WAKE_END: assert property (wakeEvent |-> $past(rxFrameEnd)) else $error("wake time");
    AST_WAKE_PULSE: assert property (frameDone |=> !wakeEvent) else $error("wake held");
    AST_SEEN_SET: assert property (wakeEvent |-> wakeFrameSeen) else $error("seen unset");
    AST_WAKE_CASES: assert property (wakeEvent |->
        $past(rxIsUnicast || rxIsBroadcast || rxPassedFilter)) else $error("bad wake");
    AST_SEEN_RISE: assert property ($rose(wakeFrameSeen) |-> wakeEvent) else $error("seen");
    AST_SEEN_HOLD: assert property ($fell(wakeFrameSeen) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i)) else $error("seen lost");
endmodule // wakeup_frame_filter_chk
`default_nettype wire

// ---- test/mac_rx_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mac_rx_model
(
    input  wire logic clk,
    output logic      rxFrameStart,
    output logic      rxByteValid,
    output logic [7:0] rxByteData,
    output logic      rxFrameEnd,
    output logic      rxIsUnicast,
    output logic      rxIsMulticast,
    output logic      rxIsBroadcast,
    output logic      rxPassedFilter
);
    initial
    begin
        {rxFrameStart, rxByteValid, rxFrameEnd, rxByteData} = 11'h0;
        {rxPassedFilter, rxIsBroadcast, rxIsMulticast, rxIsUnicast} = 4'h0;
    end
    // Type levels are only valid with the end pulse; driven inverted otherwise
    task automatic sendFrame(input logic [7:0] b[$], input logic [3:0] t);
        rxFrameStart <= 1'b1;
        {rxPassedFilter, rxIsBroadcast, rxIsMulticast, rxIsUnicast} <= ~t;
        @(posedge clk);
        rxFrameStart <= 1'b0;
        foreach (b[k])
        begin
            rxByteValid <= 1'b1;
            rxByteData <= b[k];
            @(posedge clk);
            if ($urandom_range(1))
            begin
                rxByteValid <= 1'b0;
                rxByteData <= ~b[k];
                @(posedge clk);
            end
        end
        rxByteValid <= 1'b0;
        rxFrameEnd <= 1'b1;
        {rxPassedFilter, rxIsBroadcast, rxIsMulticast, rxIsUnicast} <= t;
        @(posedge clk);
        rxFrameEnd <= 1'b0;
        {rxPassedFilter, rxIsBroadcast, rxIsMulticast, rxIsUnicast} <= ~t;
    endtask
endmodule // mac_rx_model
`default_nettype wire

// ---- test/wakeup_frame_filter_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module wakeup_frame_filter_test;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, wakeEvent, wakeFrameSeen, rxFrameStart, rxByteValid, rxFrameEnd;
    logic [7:0]  rxByteData;
    logic        rxIsUnicast, rxIsMulticast, rxIsBroadcast, rxPassedFilter;
    logic [31:0] rdQ[$];
    logic        wakeQ[$];
    logic        endSeen = 1'b0;
    int          n_mismatch = 0;
    int          compares = 0;
    always #25 clk = ~clk;
    wakeup_frame_filter dut_u (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxFrameStart, .rxByteValid, .rxByteData,
        .rxFrameEnd, .rxIsUnicast, .rxIsMulticast, .rxIsBroadcast, .rxPassedFilter,
        .wakeEvent, .wakeFrameSeen);
    mac_rx_model rx_u (.clk, .rxFrameStart, .rxByteValid, .rxByteData, .rxFrameEnd,
        .rxIsUnicast, .rxIsMulticast, .rxIsBroadcast, .rxPassedFilter);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        if (!we)
            rdQ.push_back(e);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1)
        begin
            n_mismatch++;
            end_sim;
        end
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
    endtask
    function logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
        logic [7:0] f;
        f[0] = c[15] ^ d[0];
        for (int k = 1; k < 8; k++)
            f[k] = c[15-k] ^ f[k-1] ^ d[k];
        return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3],
                f[2] ^ f[4], f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
    endfunction
    // Oldest expected note is matched against each result as it appears
    always @(posedge clk)
    begin
        if (wb_ack_o === 1'b1 && !wb_we_i)
            check(wb_dat_o, rdQ.pop_front());
        if (endSeen)
            check(32'(wakeEvent), 32'(wakeQ.pop_front()));
        endSeen <= rxFrameEnd;
    end
    initial
    begin
        logic [7:0]  fr[$];
        logic [7:0]  a;
        logic [31:0] mask, v;
        logic [15:0] crc;
        logic [3:0]  t;
        logic [1:0]  at;
        logic        en, uen, fe, hit, ok;
        int          i, off, len, f;
        void'($urandom(32'hB10D1CFB));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 40; i++)
        begin
            a = 8'h40 + 8'(4 * i);
            v = $urandom;
            wb(0, a, 0, 0);
            wb(1, a, v, 0);
            wb(0, a, 0, (i == 32 || i == 33) ? v & 32'h0F0F0F0F : v);
            wb(1, a, 0, 0);
        end
        wb(1, 8'hF0, $urandom, 0);
        wb(0, 8'hF0, 0, 0);
        for (int n = 0; n < 60; n++)
        begin
            f = $urandom_range(7);
            off = $urandom_range(6);
            len = $urandom_range(40, 4);
            mask = $urandom;
            at = 2'($urandom);
            {en, uen, fe, hit} = 4'($urandom);
            t = {1'($urandom), 3'(1 << $urandom_range(2))};
            fr = {};
            crc = 16'hFFFF;
            for (i = 0; i < len; i++)
            begin
                fr.push_back(8'($urandom));
                if (i >= off && i - off < 32 && mask[i - off])
                    crc = crcStep(crc, fr[i]);
            end
            wb(1, 8'h40 + 8'(16 * f), mask, 0);
            wb(1, 8'hC0 + 8'(4 * (f / 4)), {28'h0, at, 1'b0, en} << (8 * (f % 4)), 0);
            wb(1, 8'hC4 - 8'(4 * (f / 4)), 0, 0);
            wb(1, 8'hC8 + 8'(4 * (f / 4)), 32'(off) << (8 * (f % 4)), 0);
            wb(1, 8'hD0 + 8'(4 * (f / 2)), {16'h0, crc ^ 16'(!hit)} << (16 * (f % 2)), 0);
            v = {21'h0, 1'($urandom), uen, 8'h0, fe};
            wb(1, 8'h00, v, 0);
            wb(0, 8'h00, 0, v);
            ok = fe && en && hit && (t[0] && uen || t[0] && t[3] && at == 2'b00 ||
                 t[1] && t[3] && at == 2'b10 || t[2] || t[3] && at[0]);
            wakeQ.push_back(ok);
            rx_u.sendFrame(fr, t);
            wb(0, 8'h04, 0, ok ? (32'h1 | (32'h100 << f)) : 32'h0);
            wb(1, 8'h04, 32'h1, 0);
        end
        end_sim;
    end
endmodule // wakeup_frame_filter_test
bind wakeup_frame_filter wakeup_frame_filter_chk #(.NFILT(NFILT)) chk_u (.clk, .resetn,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .rxFrameStart, .rxByteValid, .rxByteData, .rxFrameEnd, .rxIsUnicast, .rxIsMulticast,
    .rxIsBroadcast, .rxPassedFilter, .wakeEvent, .wakeFrameSeen);
`default_nettype wire
